// *** rtl/cvl_sequencer.sv ***
// Purpose: program flow of a small 8-bit core: vectors, return stack, save buffer, table read
// Assumes: apb slave, port pins and timer events synchronous to pclk
// Notes:   lowclk_tick is a one-cycle enable from the low-frequency rc oscillator
//
// Summary of operation
// RQ1 - program memory 1K words, 16 bits
// RQ2 - four-level return stack
// RQ3 - instruction tick divides by 1 to 128
// RQ4 - most commands finish in one tick
// RQ5 - any reset: defaults, fetch from zero; pin and watchdog resets keep rom_addr
// RQ6 - cause flags 10 power, 00 watchdog, 11 pin
// RQ7 - interrupt pushes pc, jumps to eight
// RQ8 - save/restore accumulator and flags, causes untouched
// RQ9 - single save level, second save overwrites
// RQ10 - table address is high:low pointer
// RQ11 - low byte to accumulator, high to lookup
// RQ12 - no carry into high pointer
// RQ13 - three sources: two timers, external pin; the irq output also takes the table-read event when enabled
// RQ14 - external interrupt edge chosen by select
// RQ15 - external reset pin active low
// RQ16 - normal, slow, sleep, green modes
// RQ17 - enabled port change wakes core
// RQ18 - watchdog counts low-clock ticks
// RQ19 - return from interrupt pops pc
`timescale 1ns/10ps
`default_nettype none
module cvl_sequencer
    import cvl_pkg::*;
#(
    parameter int          ROM_DEPTH = ROM_WORDS,
    parameter logic [15:0] WDT_LIMIT = WDT_LIMIT_DEF
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ext_rst_n,
    input  wire logic [N_WAKE-1:0] port_in,
    input  wire logic              t0_evt,
    input  wire logic              tc0_evt,
    input  wire logic              lowclk_tick,
    output logic                   irq,
    output logic                   cpu_tick,
    output logic      [PC_W-1:0]   pc_out
);
    localparam int ROM_AW = $clog2(ROM_DEPTH);

    cvl_state_s       r;
    cvl_state_s       n;
    cvl_state_s       keep;
    logic [31:0]      rd;
    logic             err;
    logic [N_EV-1:0]  ev;
    logic [N_EV-1:0]  clr;
    logic [N_WAKE-1:0] port_chg;
    logic             ext_edge;
    logic             wdt_ovf;
    logic             exec_en;
    logic             int_take;
    logic             cmd_go;
    logic             mem_we;
    logic             mem_re;
    logic [15:0]      tbl_addr;
    logic [15:0]      mem_rdata;
    logic [6:0]       div_mask;

    // program store, also reached by software for loading
    cvl_prog_mem #(
        .DEPTH (ROM_DEPTH),
        .DW    (WORD_W)
    ) u_mem (
        .clk   (pclk),
        .we    (mem_we),
        .waddr (r.rom_addr[ROM_AW-1:0]),
        .wdata (pwdata[WORD_W-1:0]),
        .re    (mem_re),
        .raddr (tbl_addr[ROM_AW-1:0]),
        .rdata (mem_rdata)
    ); // RQ1

    // whole next state in one place
    always_comb begin
        n        = r;
        keep     = r;
        rd       = 32'h0000_0000;
        err      = 1'b0;
        clr      = '0;
        mem_we   = 1'b0;
        mem_re   = 1'b0;
        tbl_addr = {r.ptr_hi, r.ptr_lo}; // RQ10
        div_mask = 7'h7F >> (3'd7 - r.div_sel);
        wdt_ovf  = r.wdt_en && (r.wdt_cnt == WDT_LIMIT);
        exec_en  = r.tick && (r.seq == SEQ_RUN);
        int_take = exec_en && r.gie && (|(r.istat[N_SRC-1:0] & r.ien[N_SRC-1:0])); // RQ13
        cmd_go   = exec_en && !int_take && r.cmd_pend;
        // pin 0 doubles as the external interrupt input
        ext_edge = (r.edge_sel[EDGE_FALL_BIT] && r.port_q[0] && !port_in[0])
                || (r.edge_sel[EDGE_RISE_BIT] && !r.port_q[0] && port_in[0]); // RQ14
        port_chg = (port_in ^ r.port_q) & r.wake_en;
        ev          = '0;
        ev[INT_EXT] = ext_edge;
        ev[INT_T0]  = t0_evt;
        ev[INT_TC0] = tc0_evt;
        ev[INT_TBL] = (r.seq == SEQ_TBL);
        n.port_q    = port_in;

        // instruction tick: divider in normal, low clock in slow, none otherwise
        n.tick    = 1'b0;
        n.div_cnt = 7'h00;
        case (r.mode)
            MODE_NORMAL: begin
                n.tick    = (r.div_cnt >= div_mask); // RQ3
                n.div_cnt = n.tick ? 7'h00 : r.div_cnt + 7'h01;
            end
            MODE_SLOW: begin
                n.tick = lowclk_tick; // RQ16
            end
            default: begin
                n.tick = 1'b0; // RQ16
            end
        endcase

        // low-power exits: port change, or the periodic timer in green
        if ((r.mode == MODE_SLEEP || r.mode == MODE_GREEN) && (|port_chg)) begin
            n.mode = MODE_NORMAL; // RQ17
        end
        if (r.mode == MODE_GREEN && t0_evt) begin
            n.mode = MODE_NORMAL; // RQ16
        end

        // watchdog runs off the low oscillator so it survives a stopped high clock
        if (lowclk_tick && r.wdt_en) begin
            n.wdt_cnt = r.wdt_cnt + 16'h0001; // RQ18
        end

        // apb: decode in setup, answer in the first access cycle
        if (psel && !penable) begin
            n.pready = 1'b1;
            case (paddr)
                OFS_CTRL: begin
                    rd[CTRL_DIV_LSB +: 3]  = r.div_sel;
                    rd[CTRL_MODE_LSB +: 2] = r.mode;
                    rd[CTRL_GIE_BIT]       = r.gie;
                    rd[CTRL_WDT_BIT]       = r.wdt_en;
                end
                OFS_PC: begin
                    rd[PC_W-1:0]         = r.pc;
                    rd[PC_SP_LSB +: 2]   = r.sp;
                end
                OFS_ACC:    rd[7:0] = r.acc;
                OFS_FLAG:   rd[7:0] = r.flag;
                OFS_PTR: begin
                    rd[7:0]              = r.ptr_lo;
                    rd[PTR_HI_LSB +: 8]  = r.ptr_hi;
                end
                OFS_LOOKUP: rd[7:0] = r.lookup;
                OFS_EDGE:   rd[1:0] = r.edge_sel;
                OFS_WAKE:   rd[N_WAKE-1:0] = r.wake_en;
                OFS_ISTAT:  rd[N_EV-1:0] = r.istat;
                OFS_IEN:    rd[N_EV-1:0] = r.ien;
                OFS_RADDR:  rd[PC_W-1:0] = r.rom_addr;
                OFS_CMD, OFS_ICLR, OFS_RDATA, OFS_WDTCLR: begin
                    rd = 32'h0000_0000; // write-only, read as zero
                end
                default: begin
                    err = 1'b1;
                end
            endcase
            n.prdata  = pwrite ? 32'h0000_0000 : rd;
            n.pslverr = err;
        end else if (psel && penable && r.pready) begin
            n.pready  = 1'b0;
            n.pslverr = 1'b0;
            if (pwrite && !r.pslverr) begin
                case (paddr)
                    OFS_CTRL: begin
                        n.div_sel = pwdata[CTRL_DIV_LSB +: 3];
                        n.mode    = cvl_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
                        n.gie     = pwdata[CTRL_GIE_BIT];
                        n.wdt_en  = pwdata[CTRL_WDT_BIT];
                    end
                    OFS_CMD: begin
                        n.cmd      = cvl_cmd_e'(pwdata[2:0]);
                        n.cmd_addr = pwdata[CMD_ADDR_LSB +: PC_W];
                        n.cmd_pend = 1'b1;
                    end
                    OFS_ACC:  n.acc = pwdata[7:0];
                    OFS_FLAG: n.flag[5:0] = pwdata[5:0];
                    OFS_PTR: begin
                        n.ptr_lo = pwdata[7:0];
                        n.ptr_hi = pwdata[PTR_HI_LSB +: 8]; // RQ12
                    end
                    OFS_EDGE:   n.edge_sel = pwdata[1:0];
                    OFS_WAKE:   n.wake_en = pwdata[N_WAKE-1:0];
                    OFS_ICLR:   clr = pwdata[N_EV-1:0];
                    OFS_IEN:    n.ien = pwdata[N_EV-1:0];
                    OFS_RADDR:  n.rom_addr = pwdata[PC_W-1:0];
                    OFS_RDATA: begin
                        mem_we     = 1'b1;
                        n.rom_addr = r.rom_addr + 10'h001;
                    end
                    OFS_WDTCLR: n.wdt_cnt = 16'h0000;
                    default: begin
                        n.acc = r.acc;
                    end
                endcase
            end
        end

        // core execution on the instruction tick; an interrupt outranks a command
        if (int_take) begin
            n.stk[r.sp] = r.pc; // RQ2
            n.sp        = r.sp + 2'd1;
            n.pc        = INT_VEC; // RQ7
            n.gie       = 1'b0;
        end else if (cmd_go) begin
            n.cmd_pend = 1'b0;
            n.pc       = r.pc + 10'h001; // RQ4
            case (r.cmd)
                CMD_JUMP: n.pc = r.cmd_addr;
                CMD_CALL: begin
                    n.stk[r.sp] = r.pc + 10'h001; // RQ2
                    n.sp        = r.sp + 2'd1;
                    n.pc        = r.cmd_addr;
                end
                CMD_RET: begin
                    n.sp = r.sp - 2'd1;
                    n.pc = r.stk[r.sp - 2'd1];
                end
                CMD_RETURN_FROM_INTERRUPT_INSTR: begin
                    n.sp  = r.sp - 2'd1; // RQ19
                    n.pc  = r.stk[r.sp - 2'd1];
                    n.gie = 1'b1;
                end
                CMD_SAVE: begin
                    n.sav_acc  = r.acc; // RQ9
                    n.sav_flag = r.flag[5:0]; // RQ8
                end
                CMD_RESTORE: begin
                    n.acc       = r.sav_acc;
                    n.flag[5:0] = r.sav_flag; // RQ8
                end
                CMD_TBLRD: begin
                    mem_re = 1'b1; // RQ10
                    n.seq  = SEQ_TBL;
                    n.pc   = r.pc;
                end
                default: begin
                    n.pc = r.pc + 10'h001;
                end
            endcase
        end

        // table read takes one extra cycle for the registered memory read
        if (r.seq == SEQ_TBL) begin
            n.acc    = mem_rdata[7:0]; // RQ11
            n.lookup = mem_rdata[15:8]; // RQ11
            n.pc     = r.pc + 10'h001;
            n.seq    = SEQ_RUN;
        end

        // a new event wins over a clear in the same cycle
        n.istat = (r.istat & ~clr) | ev; // RQ13
        n.irq   = |(n.istat & n.ien);

        // pin and watchdog resets reload the core but keep the bus answer going
        if (!ext_rst_n || wdt_ovf) begin
            keep                = n;
            n                   = CVL_RST; // RQ5
            n.prdata            = keep.prdata;
            n.pready            = keep.pready;
            n.pslverr           = keep.pslverr;
            n.rom_addr          = keep.rom_addr;
            n.port_q            = keep.port_q;
            n.flag[FLAG_A_BIT]  = !ext_rst_n; // RQ6
            n.flag[FLAG_B_BIT]  = !ext_rst_n; // RQ15
        end
    end

    // single state register; power-on leaves the cause flags at 1,0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= CVL_RST; // RQ6
        end else begin
            r <= n;
        end
    end

    assign prdata   = r.prdata;
    assign pready   = r.pready;
    assign pslverr  = r.pslverr;
    assign irq      = r.irq;
    assign cpu_tick = r.tick;
    assign pc_out   = r.pc;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_int_vector: assert property (int_take && ext_rst_n && !wdt_ovf
        |=> r.pc == INT_VEC && r.stk[$past(r.sp)] == $past(r.pc) && !r.gie) // RQ7
        else $error("interrupt entry did not push pc and vector to eight");

    a_pin_reset: assert property (!ext_rst_n
        |=> r.pc == RESET_VEC && r.sp == 2'd0 && r.flag[7:6] == 2'b11) // RQ15
        else $error("pin reset did not restart at zero with flags 1,1");

    a_wdt_cause: assert property (wdt_ovf && ext_rst_n
        |=> r.flag[7:6] == 2'b00 && r.pc == RESET_VEC) // RQ6
        else $error("watchdog reset did not give flags 0,0");

    a_save_causes: assert property (cmd_go && ext_rst_n && !wdt_ovf
        && (r.cmd == CMD_SAVE || r.cmd == CMD_RESTORE)
        |=> $stable(r.flag[7:6])) // RQ8
        else $error("save or restore touched the reset-cause flags");

    a_tbl_result: assert property (r.seq == SEQ_TBL && ext_rst_n && !wdt_ovf
        |=> r.acc == $past(mem_rdata[7:0]) && r.lookup == $past(mem_rdata[15:8])) // RQ11
        else $error("table read did not split the word into accumulator and lookup");

    a_ptr_nocarry: assert property (!(psel && penable && pwrite && paddr == OFS_PTR)
        && ext_rst_n && !wdt_ovf |=> $stable(r.ptr_hi)) // RQ12
        else $error("high pointer moved without a software write");

    a_div_spacing: assert property (r.tick && r.mode == MODE_NORMAL && r.div_sel == 3'd2
        && $stable(r.div_sel) |=> !r.tick [*3]) // RQ3
        else $error("divide by four produced ticks closer than four cycles");

    a_sleep_still: assert property (r.mode == MODE_SLEEP ##1 r.mode == MODE_SLEEP
        |-> !r.tick) // RQ16
        else $error("instruction tick ran in sleep mode");

    a_return_from_interrupt_instr_pop: assert property (cmd_go && r.cmd == CMD_RETURN_FROM_INTERRUPT_INSTR && ext_rst_n && !wdt_ovf
        |=> r.gie && r.sp == $past(r.sp) - 2'd1) // RQ19
        else $error("return from interrupt did not pop and re-enable");

    a_wake_port: assert property (r.mode == MODE_SLEEP && (|port_chg) && ext_rst_n
        && !wdt_ovf && !(psel && penable) |=> r.mode == MODE_NORMAL) // RQ17
        else $error("enabled port change did not wake the core");

    c_int_taken: cover property (int_take);
    c_tbl_done:  cover property (r.seq == SEQ_TBL ##1 r.seq == SEQ_RUN);
    c_wdt_reset: cover property (wdt_ovf);
    c_green_wake: cover property (r.mode == MODE_GREEN ##1 r.mode == MODE_NORMAL);
endmodule
`default_nettype wire

// *** rtl/cvl_pkg.sv ***
// Purpose: shared constants, enums and state layout of the vector/lookup sequencer
// Assumes: 32-bit apb, one 100 MHz clock
// Notes:   byte offsets of the register map are all word aligned
package cvl_pkg;
    localparam int          ROM_WORDS     = 1024;
    localparam int          WORD_W        = 16;
    localparam int          PC_W          = 10;
    localparam int          STK_LEVELS    = 4;
    localparam int          N_SRC         = 3;
    localparam int          N_EV          = 4;
    localparam int          N_WAKE        = 5;
    localparam logic [9:0]  RESET_VEC     = 10'h000;
    localparam logic [9:0]  INT_VEC       = 10'h008;
    localparam logic [15:0] WDT_LIMIT_DEF = 16'h0100;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_CMD       = 8'h04;
    localparam logic [7:0]  OFS_PC        = 8'h08;
    localparam logic [7:0]  OFS_ACC       = 8'h0C;
    localparam logic [7:0]  OFS_FLAG      = 8'h10;
    localparam logic [7:0]  OFS_PTR       = 8'h14;
    localparam logic [7:0]  OFS_LOOKUP    = 8'h18;
    localparam logic [7:0]  OFS_EDGE      = 8'h1C;
    localparam logic [7:0]  OFS_WAKE      = 8'h20;
    localparam logic [7:0]  OFS_ISTAT     = 8'h24;
    localparam logic [7:0]  OFS_ICLR      = 8'h28;
    localparam logic [7:0]  OFS_IEN       = 8'h2C;
    localparam logic [7:0]  OFS_RADDR     = 8'h30;
    localparam logic [7:0]  OFS_RDATA     = 8'h34;
    localparam logic [7:0]  OFS_WDTCLR    = 8'h38;
    // field positions
    localparam int          CTRL_DIV_LSB  = 0;
    localparam int          CTRL_MODE_LSB = 4;
    localparam int          CTRL_GIE_BIT  = 6;
    localparam int          CTRL_WDT_BIT  = 7;
    localparam int          CMD_ADDR_LSB  = 16;
    localparam int          PC_SP_LSB     = 12;
    localparam int          PTR_HI_LSB    = 8;
    localparam int          FLAG_A_BIT    = 7;
    localparam int          FLAG_B_BIT    = 6;
    localparam int          EDGE_FALL_BIT = 0;
    localparam int          EDGE_RISE_BIT = 1;
    localparam int          INT_EXT       = 0;
    localparam int          INT_T0        = 1;
    localparam int          INT_TC0       = 2;
    localparam int          INT_TBL       = 3;
    // reset values
    localparam logic [7:0]  FLAG_RST      = 8'h80;
    localparam logic [1:0]  EDGE_RST      = 2'h1;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_SLOW, MODE_SLEEP, MODE_GREEN} cvl_mode_e;
    typedef enum logic [2:0] {CMD_STEP, CMD_JUMP, CMD_CALL, CMD_RET, CMD_RETURN_FROM_INTERRUPT_INSTR,
                              CMD_SAVE, CMD_RESTORE, CMD_TBLRD} cvl_cmd_e;
    typedef enum logic {SEQ_RUN, SEQ_TBL} cvl_seq_e;

    typedef struct packed {
        cvl_seq_e                         seq;
        cvl_mode_e                        mode;
        cvl_cmd_e                         cmd;
        logic                             cmd_pend;
        logic [9:0]                       cmd_addr;
        logic [9:0]                       pc;
        logic [STK_LEVELS-1:0][PC_W-1:0]  stk;
        logic [1:0]                       sp;
        logic [7:0]                       acc;
        logic [7:0]                       flag;
        logic [7:0]                       sav_acc;
        logic [5:0]                       sav_flag;
        logic [7:0]                       ptr_hi;
        logic [7:0]                       ptr_lo;
        logic [7:0]                       lookup;
        logic [2:0]                       div_sel;
        logic [6:0]                       div_cnt;
        logic                             tick;
        logic                             gie;
        logic                             wdt_en;
        logic [15:0]                      wdt_cnt;
        logic [1:0]                       edge_sel;
        logic [N_WAKE-1:0]                wake_en;
        logic [N_WAKE-1:0]                port_q;
        logic [N_EV-1:0]                  istat;
        logic [N_EV-1:0]                  ien;
        logic                             irq;
        logic [9:0]                       rom_addr;
        logic [31:0]                      prdata;
        logic                             pready;
        logic                             pslverr;
    } cvl_state_s;

    localparam cvl_state_s CVL_RST = '{seq: SEQ_RUN, mode: MODE_NORMAL, cmd: CMD_STEP,
                                       flag: FLAG_RST, edge_sel: EDGE_RST, default: '0};
endpackage

// *** rtl/cvl_prog_mem.sv ***
// Purpose: word-wide program memory, one write port, registered read port
// Assumes: single clock, read data valid one edge after re
// Notes:   no reset on the array or read register, as in a macro
`timescale 1ns/10ps
`default_nettype none
module cvl_prog_mem
    import cvl_pkg::*;
#(
    parameter int DEPTH = ROM_WORDS,
    parameter int DW    = WORD_W,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    // one word per instruction, read out through a register
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// *** verification/cvl_env_model.sv ***
// Purpose: stand-in for the timer blocks and the low-frequency rc oscillator
// Assumes: timer events are one pclk wide and synchronous to pclk
// Notes:   low tick runs free, since the rc oscillator never stops for the core
`timescale 1ns/10ps
`default_nettype none
module cvl_env_model #(
    parameter int LOW_DIV = 4
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] fire,
    output logic            t0_evt,
    output logic            tc0_evt,
    output logic            lowclk_tick
);
    logic [7:0] cnt;
    // events follow the bench request one cycle later; low tick from a free counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt         <= 8'h00;
            lowclk_tick <= 1'b0;
            t0_evt      <= 1'b0;
            tc0_evt     <= 1'b0;
        end else begin
            cnt         <= (cnt == 8'(LOW_DIV - 1)) ? 8'h00 : cnt + 8'h01;
            lowclk_tick <= (cnt == 8'(LOW_DIV - 1));
            t0_evt      <= fire[0];
            tc0_evt     <= fire[1];
        end
    end
endmodule
`default_nettype wire

// *** verification/cpu_vector_lookup_sequencer_bench.sv ***
// Purpose: self-checking bench for the vector/lookup sequencer over apb
// Assumes: commands run on the next instruction tick, apb answer is waited for
// Notes:   pc holds between commands, so stack checks read it directly
`timescale 1ns/10ps
`default_nettype none
module cpu_vector_lookup_sequencer_bench;
    import cvl_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic              ext_rst_n = 1'b1;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata, rd;
    logic              rd_err;
    logic              pready, pslverr, irq, cpu_tick, t0_evt, tc0_evt, lowclk_tick;
    logic [N_WAKE-1:0] port_in = 5'h1F;
    logic [1:0]        fire = 2'h0;
    logic [PC_W-1:0]   pc_out;
    int                fail_count = 0;
    int                check_count = 0;
    int                tick_cnt = 0;
    int                snap;

    always #5 pclk = ~pclk;
    // counted at the falling edge so the count never races the tick register
    always @(negedge pclk) if (cpu_tick === 1'b1) tick_cnt++;

    cvl_sequencer #(.ROM_DEPTH(1024), .WDT_LIMIT(16'h0004)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_rst_n(ext_rst_n), .port_in(port_in), .t0_evt(t0_evt),
        .tc0_evt(tc0_evt), .lowclk_tick(lowclk_tick), .irq(irq), .cpu_tick(cpu_tick),
        .pc_out(pc_out));
    cvl_env_model #(.LOW_DIV(4)) env (.pclk(pclk), .presetn(presetn), .fire(fire),
        .t0_evt(t0_evt), .tc0_evt(tc0_evt), .lowclk_tick(lowclk_tick));

    task automatic final_report();
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic cmd(input logic [2:0] op, input logic [9:0] t);
        apb(1'b1, OFS_CMD, {6'h0, t, 13'h0, op});
        repeat (4) @(posedge pclk);
    endtask
    task automatic pulse(input logic [1:0] f);
        @(posedge pclk);
        fire <= f;
        @(posedge pclk);
        fire <= 2'h0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic window(input logic [31:0] exp);
        // skip the edges that still run on the old divider or mode
        repeat (8) @(posedge pclk);
        snap = tick_cnt;
        repeat (256) @(posedge pclk);
        chk(32'(tick_cnt - snap), exp);
    endtask

    task automatic t_table();
        apb(1'b1, OFS_RADDR, 32'h1FF);
        apb(1'b1, OFS_RDATA, 32'hA55A);
        apb(1'b1, OFS_RADDR, 32'h3FF);
        apb(1'b1, OFS_RDATA, 32'h5A1C);
        apb(1'b1, OFS_PTR, 32'h01FF);
        cmd(CMD_TBLRD, 10'h0);
        rchk(OFS_ACC, 32'h5A);
        rchk(OFS_LOOKUP, 32'hA5);
        rchk(OFS_PTR, 32'h01FF);
        apb(1'b1, OFS_PTR, 32'h03FF);
        cmd(CMD_TBLRD, 10'h0);
        rchk(OFS_ACC, 32'h1C);
        rchk(OFS_LOOKUP, 32'h5A);
        rchk(OFS_ISTAT, 32'h8);
        apb(1'b1, OFS_ICLR, 32'h8);
    endtask
    task automatic t_stack();
        cmd(CMD_JUMP, 10'h100);
        cmd(CMD_CALL, 10'h200);
        rchk(OFS_PC, 32'h1200);
        cmd(CMD_CALL, 10'h300);
        rchk(OFS_PC, 32'h2300);
        cmd(CMD_RET, 10'h0);
        rchk(OFS_PC, 32'h1201);
        cmd(CMD_RET, 10'h0);
        rchk(OFS_PC, 32'h0101);
        chk(32'(pc_out), 32'h101);
    endtask
    task automatic t_save();
        apb(1'b1, OFS_ACC, 32'h11);
        apb(1'b1, OFS_FLAG, 32'h05);
        cmd(CMD_SAVE, 10'h0);
        apb(1'b1, OFS_ACC, 32'h22);
        apb(1'b1, OFS_FLAG, 32'h0A);
        cmd(CMD_SAVE, 10'h0);
        apb(1'b1, OFS_ACC, 32'h33);
        apb(1'b1, OFS_FLAG, 32'h00);
        cmd(CMD_RESTORE, 10'h0);
        rchk(OFS_ACC, 32'h22);
        rchk(OFS_FLAG, 32'h8A);
    endtask
    task automatic t_irq();
        port_in <= 5'h1E;
        repeat (3) @(posedge pclk);
        rchk(OFS_ISTAT, 32'h1);
        apb(1'b1, OFS_ICLR, 32'h1);
        port_in <= 5'h1F;
        repeat (3) @(posedge pclk);
        rchk(OFS_ISTAT, 32'h0);
        apb(1'b1, OFS_EDGE, 32'h2);
        port_in <= 5'h1E;
        repeat (3) @(posedge pclk);
        rchk(OFS_ISTAT, 32'h0);
        port_in <= 5'h1F;
        repeat (3) @(posedge pclk);
        rchk(OFS_ISTAT, 32'h1);
        apb(1'b1, OFS_ICLR, 32'h1);
        pulse(2'h1);
        chk({31'h0, irq}, 32'h0);
        pulse(2'h2);
        rchk(OFS_ISTAT, 32'h6);
        apb(1'b1, OFS_ICLR, 32'h7);
        cmd(CMD_JUMP, 10'h030);
        apb(1'b1, OFS_IEN, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h40);
        pulse(2'h1);
        chk({31'h0, irq}, 32'h1);
        rchk(OFS_PC, 32'h1008);
        apb(1'b1, OFS_ICLR, 32'h2);
        // irq falls at the clear edge, so look one edge later
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        cmd(CMD_RETURN_FROM_INTERRUPT_INSTR, 10'h0);
        rchk(OFS_PC, 32'h0030);
    endtask
    task automatic t_modes();
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, OFS_CTRL, 32'(k));
            window(32'(256 >> k));
        end
        apb(1'b1, OFS_CTRL, 32'h10);
        window(32'h40);
        apb(1'b1, OFS_CTRL, 32'h20);
        window(32'h0);
        apb(1'b1, OFS_WAKE, 32'h02);
        port_in <= 5'h1D;
        repeat (3) @(posedge pclk);
        rchk(OFS_CTRL, 32'h0);
        port_in <= 5'h1F;
        apb(1'b1, OFS_CTRL, 32'h30);
        pulse(2'h1);
        rchk(OFS_CTRL, 32'h0);
    endtask
    task automatic t_resets();
        cmd(CMD_JUMP, 10'h055);
        ext_rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        ext_rst_n <= 1'b1;
        rchk(OFS_FLAG, 32'hC0);
        rchk(OFS_PC, 32'h0);
        apb(1'b1, OFS_ACC, 32'h77);
        apb(1'b1, OFS_CTRL, 32'h80);
        repeat (40) @(posedge pclk);
        rchk(OFS_FLAG, 32'h00);
        rchk(OFS_ACC, 32'h00);
    endtask

    // main sequence: power-on reset, then one task per scenario
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(OFS_FLAG, 32'h80);
        rchk(OFS_PC, 32'h0);
        rchk(OFS_EDGE, 32'h1);
        chk({31'h0, rd_err}, 32'h0);
        rchk(8'h3C, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        t_table();
        t_stack();
        t_save();
        t_irq();
        t_modes();
        t_resets();
        final_report();
    end
    // watchdog: the whole run needs well under 10000 cycles
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
